/* File: rtl/asc_pkg.sv */
`default_nettype none
package asc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int NODATA_TIME_MS = 41;
  localparam int MUX_WD_TIME_MS = 327;

  // ----------------------------------------------------------------
  // received telegram layout
  // ----------------------------------------------------------------
  localparam int FRM_W       = 14;
  localparam int FRM_ST      = 13;
  localparam int FRM_CB      = 12;
  localparam int FRM_ADDR_HI = 11;
  localparam int FRM_ADDR_LO = 7;
  localparam int FRM_INFO_HI = 6;
  localparam int FRM_INFO_LO = 2;
  localparam int FRM_PB      = 1;
  localparam int FRM_EB      = 0;

  // ----------------------------------------------------------------
  // call codes and replies
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_ZERO    = 5'h00;
  localparam logic [4:0] ADDR_BCAST   = 5'h1f;
  localparam logic [4:0] INFO_BCAST   = 5'h15;
  localparam logic [4:0] INFO_SET_ID  = 5'h18;
  localparam logic [4:0] INFO_SET_IO  = 5'h19;
  localparam logic [4:0] INFO_SET_ID2 = 5'h1a;
  localparam logic [4:0] INFO_SET_CC  = 5'h1b;
  localparam logic [4:0] INFO_SET_CC2 = 5'h14;
  localparam logic [2:0] LOW_DELETE   = 3'h0;
  localparam logic [2:0] LOW_RESET    = 3'h4;
  localparam logic [2:0] LOW_STATUS   = 3'h6;
  localparam logic [3:0] REPLY_ACK    = 4'h6;
  localparam logic [3:0] REPLY_ZERO   = 4'h0;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CFG    = 4'h0;
  localparam logic [3:0] REG_CODES  = 4'h1;
  localparam logic [3:0] REG_ADDR   = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_TABLE  = 4'h4;
  localparam logic [3:0] REG_SYNC   = 4'h5;

  localparam int CFG_EXT_ADDR  = 0;
  localparam int CFG_FOUR_OUT  = 1;
  localparam int CFG_SYNC_IO   = 2;
  localparam int CFG_SAFETY    = 3;
  localparam int CFG_MUX_WD    = 4;
  localparam int CFG_COMM_WD   = 5;
  localparam int CFG_PRG_LOCK  = 6;
  localparam int CFG_SAFE_PDIS = 7;
  localparam int CFG_INVERT    = 8;
  localparam int CFG_FILTER    = 9;
  localparam int CODES_EXT1_LO = 12;
  localparam int CODES_SEL     = 15;

  localparam logic [15:0] CFG_RST   = 16'h0000;
  localparam logic [15:0] CODES_RST = 16'hffff;
  localparam logic [4:0]  ADDR_RST  = 5'h00;
  localparam logic [3:0]  PARAM_RST = 4'hf;

  // ----------------------------------------------------------------
  // shared decoding
  // ----------------------------------------------------------------
  function automatic logic sel_ok(input logic i3, input logic sel,
                                  input logic inv, input logic ext);
    sel_ok = (i3 == (ext ? (sel ^ inv) : inv));
  endfunction

  function automatic logic parity4(input logic [3:0] d);
    parity4 = ^d;
  endfunction

endpackage
`default_nettype wire

/* File: rtl/asc_ms_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module asc_ms_timer #(
  parameter int LIMIT = 41
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic enable,
  input  wire logic kick,
  output logic      expired
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // ----------------------------------------------------------------
  // millisecond count, restarted by kick
  // ----------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    if (!enable || kick) begin
      cnt_nxt = '0;
    end else if (tick && cnt_r != LIM) begin
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign expired = (cnt_r == LIM);
endmodule
`default_nettype wire

/* File: rtl/asc_code_table.sv */
`timescale 1ns/1ps
`default_nettype none
module asc_code_table #(
  parameter int DEPTH = 8,
  parameter int W     = 4
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [W-1:0]             wr_val,
  input  wire logic                     advance,
  input  wire logic                     restart,
  output logic      [W-1:0]             code,
  output logic      [$clog2(DEPTH)-1:0] ptr
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_r [DEPTH];
  logic [W-1:0]  mem_nxt [DEPTH];
  logic [AW-1:0] ptr_r;
  logic [AW-1:0] ptr_nxt;

  // ----------------------------------------------------------------
  // table storage and cycling pointer
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (wr_en) begin
      mem_nxt[wr_idx] = wr_val;
    end
    ptr_nxt = ptr_r;
    if (restart) begin
      ptr_nxt = '0;
    end else if (advance) begin
      ptr_nxt = (ptr_r == AW'(DEPTH - 1)) ? '0 : ptr_r + AW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      ptr_r <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
      ptr_r <= ptr_nxt;
    end
  end

  assign code = mem_r[ptr_r];
  assign ptr  = ptr_r;
endmodule
`default_nettype wire

/* File: rtl/asc_slave.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (RQ1) in sync mode a falling slave address marks the lowest slave and sync point
// (RQ2) normal addressing drives output three from I3; extended uses I3 as select
// (RQ3) four-output extended mode updates one 2-bit half chosen by I2
// (RQ4) optional watchdog flags a fault when I2 stops alternating 327 ms
// (RQ5) safety mode answers data exchange from an eight-entry cycling code table
// (RQ6) safety mode disables inversion and filtering; inputs become three-level
// (RQ7) first LED flags no data or parameter exchange for 41 ms
// (RQ8) with its flags set the monitor resets the device on expiry
// (RQ9) parameter pin zero level switches the communication watchdog on and off
// (RQ10) manufacturer calls are ignored once lock and safety disable flags are set
// (RQ11) module maker sets the program disable flag before field delivery
// (RQ12) extended addressing compares I3, true or inverted, with own A/B select
// (RQ13) extended addressing stays off while the programming lock flag is low
// (RQ14) data exchange drives outputs and answers the four sampled inputs
// (RQ15) parameter write updates the parameter port and returns the value
// (RQ16) address assignment at address zero stores new address, answers 0110
// (RQ17) ext id one write at address zero stores the code, answers zero
// (RQ18) delete address answers zero; reset slave resets and answers 0110
// (RQ19) read calls return io config, id, ext id one or ext id two
// (RQ20) read status answers the four status bits
// (RQ21) broadcast reset resets every slave without any reply
// (RQ22) manufacturer set calls answer 0110; safety program entry gets none
// (RQ23) status bit zero shows pending memory write, bit three the security flag
// (RQ24) parity and framing checked on receive, parity generated on reply
module asc_slave
  import asc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic              MCLK,
  input  wire logic              RSTN,
  input  wire logic              RX_VALID,
  input  wire logic [FRM_W-1:0]  RX_FRAME,
  input  wire logic [3:0]        DATA_IN,
  input  wire logic [3:0]        PARAM_IN,
  input  wire logic              EE_WRITE_PENDING,
  input  wire logic              SECURITY_FLAG,
  input  wire logic              PERIPHERY_FAULT,
  input  wire logic [3:0]        REG_ADDR_IN,
  input  wire logic [15:0]       REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [15:0]       REG_RDATA,
  output logic                   TX_VALID,
  output logic      [3:0]        TX_INFO,
  output logic                   TX_PARITY,
  output logic                   TX_END,
  output logic      [3:0]        DATA_OUT,
  output logic      [3:0]        PARAM_OUT,
  output logic                   SYNC_POINT,
  output logic                   FIRST_LED_OUTPUT,
  output logic                   MUX_FAULT,
  output logic                   DEVICE_RESET,
  output logic                   FILTER_ACTIVE,
  output logic                   INPUT_3LEVEL
);
  localparam int DW = $clog2(TICK_CYC);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]   cfg_r, cfg_nxt;
  logic [15:0]   codes_r, codes_nxt;
  logic [4:0]    addr_r, addr_nxt;
  logic [3:0]    dout_r, dout_nxt;
  logic [3:0]    pend_r, pend_nxt;
  logic [3:0]    pout_r, pout_nxt;
  logic          txv_r, txv_nxt;
  logic [3:0]    txi_r, txi_nxt;
  logic          sync_r, sync_nxt;
  logic [4:0]    last_r, last_nxt;
  logic [4:0]    low_r, low_nxt;
  logic          i2_r, i2_nxt;
  logic          rst_r, rst_nxt;
  logic [15:0]   rdata_r, rdata_nxt;
  logic [DW-1:0] div_r, div_nxt;

  // ----------------------------------------------------------------
  // telegram fields and decode
  // ----------------------------------------------------------------
  logic       frame_ok, cb, mine, mine_cb, ext_active, sel, i3;
  logic [4:0] rx_addr, info;
  logic       is_data_exchange_call, is_parameter_write_call, is_adra, is_ext_id1_write_call, is_address_delete_call, is_res;
  logic       is_rd, is_status_read_call, is_bcast, is_manuf, dx_any, manuf_en;
  logic       soft_rst, is_sync, tick;
  logic       nodata_exp, mux_exp, wd_active, mux_mode;
  logic       parameter_pin_zero, output_pin_three;
  logic [3:0] code_val, in_val, new_out, status_bits;
  logic [2:0] code_ptr;

  assign rx_addr    = RX_FRAME[FRM_ADDR_HI:FRM_ADDR_LO];
  assign info       = RX_FRAME[FRM_INFO_HI:FRM_INFO_LO];
  assign cb         = RX_FRAME[FRM_CB];
  assign i3         = info[3];
  assign frame_ok   = RX_VALID && !RX_FRAME[FRM_ST] && RX_FRAME[FRM_EB]
                      && !(^RX_FRAME[FRM_ST:FRM_PB]);  // RQ24
  assign ext_active = cfg_r[CFG_EXT_ADDR] && cfg_r[CFG_PRG_LOCK];  // RQ13
  assign sel        = codes_r[CODES_SEL];
  assign manuf_en   = !(cfg_r[CFG_PRG_LOCK] && cfg_r[CFG_SAFE_PDIS]);  // RQ10
  assign mine       = (rx_addr == addr_r);
  assign mine_cb    = frame_ok && cb && mine && (rx_addr != ADDR_BCAST);

  assign dx_any   = frame_ok && !cb && !info[4] && (rx_addr != ADDR_ZERO);
  assign is_data_exchange_call  = dx_any && mine
                    && (!ext_active || sel_ok(i3, sel, 1'b1, 1'b1));  // RQ12
  assign is_parameter_write_call  = frame_ok && !cb && info[4] && mine && (addr_r != ADDR_ZERO)
                    && (!ext_active || sel_ok(i3, sel, 1'b1, 1'b1));  // RQ12
  assign is_adra  = frame_ok && !cb && (rx_addr == ADDR_ZERO)
                    && (addr_r == ADDR_ZERO);
  assign is_ext_id1_write_call  = frame_ok && cb && (rx_addr == ADDR_ZERO) && !info[4];
  assign is_address_delete_call  = mine_cb && !is_ext_id1_write_call && !info[4] && (info[2:0] == LOW_DELETE)
                    && sel_ok(i3, sel, 1'b0, ext_active);
  assign is_res   = mine_cb && info[4] && (info[2:0] == LOW_RESET)
                    && sel_ok(i3, sel, 1'b1, ext_active);
  assign is_rd    = mine_cb && info[4] && !info[2]
                    && sel_ok(i3, sel, 1'b0, ext_active);
  assign is_status_read_call  = mine_cb && info[4] && (info[2:0] == LOW_STATUS)
                    && sel_ok(i3, sel, 1'b1, ext_active);
  assign is_bcast = frame_ok && cb && (rx_addr == ADDR_BCAST)
                    && (info == INFO_BCAST);  // RQ21
  assign is_manuf = mine_cb && manuf_en && !is_res && !is_rd && !is_status_read_call
                    && ((info == INFO_SET_ID) || (info == INFO_SET_IO)
                    || (info == INFO_SET_ID2) || (info == INFO_SET_CC)
                    || (info == INFO_SET_CC2));  // RQ10

  assign soft_rst = is_res || is_bcast || rst_r;  // RQ18 RQ21 RQ8

  assign is_sync = cfg_r[CFG_SYNC_IO] && dx_any
                   && ((rx_addr < last_r) || (rx_addr == low_r));  // RQ1

  assign parameter_pin_zero = PARAM_IN[0];
  assign wd_active = cfg_r[CFG_COMM_WD] && parameter_pin_zero;  // RQ9
  assign mux_mode  = ext_active && cfg_r[CFG_FOUR_OUT];

  // ----------------------------------------------------------------
  // input path and status bits
  // ----------------------------------------------------------------
  always_comb begin
    if (cfg_r[CFG_SAFETY]) begin
      in_val = code_val;  // RQ5
    end else if (cfg_r[CFG_INVERT]) begin
      in_val = ~DATA_IN;  // RQ6
    end else begin
      in_val = DATA_IN;
    end
    status_bits = {SECURITY_FLAG, 1'b0, PERIPHERY_FAULT, EE_WRITE_PENDING};  // RQ23
  end

  // ----------------------------------------------------------------
  // new output word for a data exchange
  // ----------------------------------------------------------------
  always_comb begin
    new_out = cfg_r[CFG_SYNC_IO] ? pend_r : dout_r;
    if (mux_mode) begin
      if (info[2]) begin
        new_out[3:2] = info[1:0];  // RQ3
      end else begin
        new_out[1:0] = info[1:0];  // RQ3
      end
    end else if (ext_active) begin
      new_out[2:0] = info[2:0];  // RQ2
    end else begin
      new_out = info[3:0];  // RQ2 RQ14
    end
  end

  // ----------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------
  always_comb begin
    dout_nxt = dout_r;
    pend_nxt = pend_r;
    pout_nxt = pout_r;
    addr_nxt = addr_r;
    txv_nxt  = 1'b0;
    txi_nxt  = txi_r;
    sync_nxt = 1'b0;
    last_nxt = last_r;
    low_nxt  = low_r;
    i2_nxt   = i2_r;
    rst_nxt  = wd_active && nodata_exp && !rst_r;  // RQ8
    if (dx_any) begin
      last_nxt = rx_addr;
      if (cfg_r[CFG_SYNC_IO] && (rx_addr < last_r)) begin
        low_nxt = rx_addr;  // RQ1
      end
    end
    if (is_data_exchange_call) begin
      i2_nxt  = info[2];
      txv_nxt = 1'b1;
      txi_nxt = in_val;  // RQ14
      if (cfg_r[CFG_SYNC_IO]) begin
        pend_nxt = new_out;
      end else begin
        dout_nxt = new_out;
      end
    end
    if (is_sync) begin
      sync_nxt = 1'b1;
      dout_nxt = is_data_exchange_call ? new_out : pend_r;  // RQ1
    end
    if (is_parameter_write_call) begin
      pout_nxt = ext_active ? {pout_r[3], info[2:0]} : info[3:0];  // RQ15
      txv_nxt  = 1'b1;
      txi_nxt  = ext_active ? {pout_r[3], info[2:0]} : info[3:0];  // RQ15
    end
    if (is_adra) begin
      addr_nxt = info;  // RQ16
      txv_nxt  = 1'b1;
      txi_nxt  = REPLY_ACK;
    end
    if (is_ext_id1_write_call || is_address_delete_call) begin
      txv_nxt = 1'b1;
      txi_nxt = REPLY_ZERO;  // RQ17 RQ18
    end
    if (is_address_delete_call) begin
      addr_nxt = ADDR_ZERO;  // RQ18
    end
    if (is_res || is_manuf) begin
      txv_nxt = 1'b1;
      txi_nxt = REPLY_ACK;  // RQ18 RQ22
    end
    if (is_rd) begin
      txv_nxt = 1'b1;
      case (info[1:0])
        2'h0:    txi_nxt = codes_r[3:0];  // RQ19
        2'h1:    txi_nxt = codes_r[7:4];
        2'h2:    txi_nxt = codes_r[15:12];
        default: txi_nxt = codes_r[11:8];
      endcase
    end
    if (is_status_read_call) begin
      txv_nxt = 1'b1;
      txi_nxt = status_bits;  // RQ20
    end
    if (soft_rst) begin
      dout_nxt = 4'h0;
      pend_nxt = 4'h0;
      pout_nxt = PARAM_RST;
      sync_nxt = 1'b0;
      if (!is_res) begin
        txv_nxt = 1'b0;  // RQ21
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      dout_r <= 4'h0;
      pend_r <= 4'h0;
      pout_r <= PARAM_RST;
      addr_r <= ADDR_RST;
      txv_r  <= 1'b0;
      txi_r  <= 4'h0;
      sync_r <= 1'b0;
      last_r <= 5'h00;
      low_r  <= 5'h00;
      i2_r   <= 1'b0;
      rst_r  <= 1'b0;
    end else begin
      dout_r <= dout_nxt;
      pend_r <= pend_nxt;
      pout_r <= pout_nxt;
      addr_r <= addr_nxt;
      txv_r  <= txv_nxt;
      txi_r  <= txi_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
      low_r  <= low_nxt;
      i2_r   <= i2_nxt;
      rst_r  <= rst_nxt;
    end
  end

  // ----------------------------------------------------------------
  // register bus and configuration
  // ----------------------------------------------------------------
  always_comb begin
    cfg_nxt   = cfg_r;
    codes_nxt = codes_r;
    rdata_nxt = 16'h0000;
    if (REG_WR) begin
      case (REG_ADDR_IN)
        REG_CFG:   cfg_nxt   = REG_WDATA;
        REG_CODES: codes_nxt = REG_WDATA;
        default:   cfg_nxt   = cfg_r;
      endcase
    end
    if (is_ext_id1_write_call) begin
      codes_nxt[CODES_EXT1_LO +: 4] = info[3:0];  // RQ17
    end
    if (REG_RD) begin
      case (REG_ADDR_IN)
        REG_CFG:    rdata_nxt = cfg_r;
        REG_CODES:  rdata_nxt = codes_r;
        REG_ADDR:   rdata_nxt = {11'h000, addr_r};
        REG_STATUS: rdata_nxt = {5'h00, code_ptr, 1'b0, ext_active, MUX_FAULT,
                                 FIRST_LED_OUTPUT, status_bits};
        REG_SYNC:   rdata_nxt = {11'h000, low_r};
        default:    rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      cfg_r   <= CFG_RST;
      codes_r <= CODES_RST;
      rdata_r <= 16'h0000;
    end else begin
      cfg_r   <= cfg_nxt;
      codes_r <= codes_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  always_comb begin
    div_nxt = (div_r == DW'(TICK_CYC - 1)) ? '0 : div_r + DW'(1);
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign tick = (div_r == DW'(TICK_CYC - 1));

  // ----------------------------------------------------------------
  // timers and code table
  // ----------------------------------------------------------------
  asc_ms_timer #(
    .LIMIT (NODATA_TIME_MS)
  ) u_nodata (
    .clk     (MCLK),
    .rst_n   (RSTN),
    .tick    (tick),
    .enable  (1'b1),
    .kick    (is_data_exchange_call || is_parameter_write_call || rst_r),  // RQ7
    .expired (nodata_exp)
  );

  asc_ms_timer #(
    .LIMIT (MUX_WD_TIME_MS)
  ) u_muxwd (
    .clk     (MCLK),
    .rst_n   (RSTN),
    .tick    (tick),
    .enable  (mux_mode && cfg_r[CFG_MUX_WD]),  // RQ4
    .kick    (is_data_exchange_call && (info[2] != i2_r)),  // RQ4
    .expired (mux_exp)
  );

  asc_code_table #(
    .DEPTH (8),
    .W     (4)
  ) u_table (
    .clk     (MCLK),
    .rst_n   (RSTN),
    .wr_en   (REG_WR && (REG_ADDR_IN == REG_TABLE)),
    .wr_idx  (REG_WDATA[2:0]),
    .wr_val  (REG_WDATA[7:4]),
    .advance (is_data_exchange_call && cfg_r[CFG_SAFETY]),  // RQ5
    .restart (soft_rst),
    .code    (code_val),
    .ptr     (code_ptr)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign output_pin_three = dout_r[3];
  assign DATA_OUT         = {output_pin_three, dout_r[2:0]};
  assign PARAM_OUT        = pout_r;
  assign TX_VALID         = txv_r;
  assign TX_INFO          = txi_r;
  assign TX_PARITY        = parity4(txi_r);  // RQ24
  assign TX_END           = 1'b1;
  assign SYNC_POINT       = sync_r;
  assign FIRST_LED_OUTPUT = nodata_exp;  // RQ7
  assign MUX_FAULT        = mux_exp;  // RQ4
  assign DEVICE_RESET     = rst_r;  // RQ8
  assign FILTER_ACTIVE    = cfg_r[CFG_FILTER] && !cfg_r[CFG_SAFETY];  // RQ6
  assign INPUT_3LEVEL     = cfg_r[CFG_SAFETY];  // RQ6
  assign REG_RDATA        = rdata_r;
endmodule
`default_nettype wire

/* File: testbench/asc_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module asc_master_model (
  input  wire logic        clk,
  output logic             rx_valid,
  output logic [13:0]      rx_frame
);
  // ---
  // telegram issue
  // ---
  initial begin
    rx_valid = 1'b0;
    rx_frame = 14'h0000;
  end
  task automatic send(input logic cb, input logic [4:0] a, input logic [4:0] i,
                      input logic bad);
    logic [13:0] f;
    f = {1'b0, cb, a, i, (^{cb, a, i}) ^ bad, 1'b1};
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_frame <= ~f;
  endtask
endmodule
`default_nettype wire

/* File: testbench/asc_slave_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module asc_slave_monitor
  import asc_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RSTN,
  input wire logic        RX_VALID,
  input wire logic [13:0] RX_FRAME,
  input wire logic        TX_VALID,
  input wire logic [3:0]  TX_INFO,
  input wire logic        TX_PARITY,
  input wire logic        TX_END,
  input wire logic [3:0]  DATA_IN,
  input wire logic [3:0]  PARAM_OUT,
  input wire logic        FILTER_ACTIVE,
  input wire logic        INPUT_3LEVEL
);
  default clocking dc @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  logic [13:0] frm_q;
  logic [3:0]  din_q;
  always_ff @(posedge MCLK) begin
    frm_q <= RX_FRAME;
    din_q <= DATA_IN;
  end
  a_reply_latency: assert property (TX_VALID |-> $past(RX_VALID))
    else $error("reply without telegram");
  a_parity_gen: assert property (TX_VALID |-> TX_PARITY == ^TX_INFO)
    else $error("reply parity wrong");
  a_end_bit: assert property (TX_VALID |-> TX_END)
    else $error("end bit low");
  a_bad_parity: assert property (RX_VALID && ^RX_FRAME[13:1] |=> !TX_VALID)
    else $error("bad telegram answered");
  a_bcast_silent: assert property (RX_VALID && RX_FRAME[12:2] == 11'h7f5 |=> !TX_VALID)
    else $error("broadcast answered");
  a_prgm_silent: assert property (RX_VALID && RX_FRAME[12:2] == 11'h41d |=> !TX_VALID)
    else $error("program entry answered");
  a_data_exchange_call_data: assert property (TX_VALID && !INPUT_3LEVEL && frm_q[12:6] != 7'h00
    && !frm_q[12] && !frm_q[6] |-> TX_INFO == din_q)
    else $error("data exchange reply wrong");
  a_param_echo: assert property (TX_VALID && !frm_q[12] && frm_q[6] && frm_q[11:7] != 5'h00
    |-> TX_INFO[2:0] == PARAM_OUT[2:0])
    else $error("parameter echo wrong");
  a_adra_ack: assert property (TX_VALID && frm_q[12:7] == 6'h00 |-> TX_INFO == REPLY_ACK)
    else $error("address assignment reply wrong");
  a_filter_off: assert property (INPUT_3LEVEL |-> !FILTER_ACTIVE)
    else $error("filter on in safety mode");
  c_reply: cover property (TX_VALID);
  c_safety: cover property (INPUT_3LEVEL && TX_VALID);
  c_param: cover property (TX_VALID && frm_q[6]);
endmodule
bind asc_slave asc_slave_monitor asc_slave_monitor_i (.MCLK(MCLK), .RSTN(RSTN),
  .RX_VALID(RX_VALID), .RX_FRAME(RX_FRAME), .TX_VALID(TX_VALID), .TX_INFO(TX_INFO),
  .TX_PARITY(TX_PARITY), .TX_END(TX_END), .DATA_IN(DATA_IN), .PARAM_OUT(PARAM_OUT),
  .FILTER_ACTIVE(FILTER_ACTIVE), .INPUT_3LEVEL(INPUT_3LEVEL));
`default_nettype wire

/* File: testbench/asc_slave_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module asc_slave_bench
  import asc_pkg::*;
;
  localparam int TCK = 10;
  logic        MCLK, RSTN, RX_VALID, EE_WRITE_PENDING, SECURITY_FLAG, REG_WR, REG_RD;
  logic [13:0] RX_FRAME;
  logic [3:0]  DATA_IN, PARAM_IN, REG_ADDR_IN, TX_INFO, DATA_OUT, PARAM_OUT;
  logic [15:0] REG_WDATA, REG_RDATA;
  logic        TX_VALID, TX_PARITY, TX_END, SYNC_POINT, FIRST_LED_OUTPUT, MUX_FAULT;
  logic        DEVICE_RESET, FILTER_ACTIVE, INPUT_3LEVEL;
  int          bad_count, total_checks;
  asc_master_model asc_master_model_i (.clk(MCLK), .rx_valid(RX_VALID), .rx_frame(RX_FRAME));
  asc_slave #(.TICK_CYC(TCK)) asc_slave_i (.MCLK(MCLK), .RSTN(RSTN), .RX_VALID(RX_VALID),
    .RX_FRAME(RX_FRAME), .DATA_IN(DATA_IN), .PARAM_IN(PARAM_IN),
    .EE_WRITE_PENDING(EE_WRITE_PENDING), .SECURITY_FLAG(SECURITY_FLAG),
    .PERIPHERY_FAULT(1'b0), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .TX_VALID(TX_VALID),
    .TX_INFO(TX_INFO), .TX_PARITY(TX_PARITY), .TX_END(TX_END), .DATA_OUT(DATA_OUT),
    .PARAM_OUT(PARAM_OUT), .SYNC_POINT(SYNC_POINT), .FIRST_LED_OUTPUT(FIRST_LED_OUTPUT),
    .MUX_FAULT(MUX_FAULT), .DEVICE_RESET(DEVICE_RESET), .FILTER_ACTIVE(FILTER_ACTIVE),
    .INPUT_3LEVEL(INPUT_3LEVEL));
  // ---
  // shared tasks
  // ---
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic regw(input logic [3:0] a, input logic [15:0] d);
    @(posedge MCLK);
    REG_ADDR_IN <= a;
    REG_WDATA   <= d;
    REG_WR      <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask
  task automatic regr(input logic [3:0] a, input logic [15:0] e);
    @(posedge MCLK);
    REG_ADDR_IN <= a;
    REG_RD      <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 chk("rdata", REG_RDATA, e);
  endtask
  task automatic call(input logic cb, input logic [4:0] a, input logic [4:0] i,
                      input logic bad, input logic ev, input logic [3:0] ei);
    asc_master_model_i.send(cb, a, i, bad);
    #1 chk("reply", {15'h0000, TX_VALID}, {15'h0000, ev});
    if (ev) chk("info", {12'h000, TX_INFO}, {12'h000, ei});
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ---
  // scenarios
  // ---
  task automatic t_basic();
    regr(REG_CFG, 16'h0000);
    regr(REG_CODES, 16'hffff);
    regr(4'hf, 16'h0000);
    call(1'b0, 5'h00, 5'h05, 1'b0, 1'b1, REPLY_ACK);
    regr(REG_ADDR, 16'h0005);
    @(posedge MCLK);
    DATA_IN <= 4'h3;
    call(1'b0, 5'h05, 5'h0a, 1'b0, 1'b1, 4'h3);
    chk("dout", {12'h000, DATA_OUT}, 16'h000a);
    call(1'b0, 5'h05, 5'h05, 1'b1, 1'b0, 4'h0);
    call(1'b0, 5'h06, 5'h05, 1'b0, 1'b0, 4'h0);
    chk("dout", {12'h000, DATA_OUT}, 16'h000a);
    call(1'b0, 5'h05, 5'h15, 1'b0, 1'b1, 4'h5);
    chk("pout", {12'h000, PARAM_OUT}, 16'h0005);
    call(1'b1, 5'h1f, 5'h15, 1'b0, 1'b0, 4'h0);
    chk("pout", {12'h000, PARAM_OUT}, 16'h000f);
  endtask
  task automatic t_calls();
    @(posedge MCLK);
    EE_WRITE_PENDING <= 1'b1;
    SECURITY_FLAG    <= 1'b1;
    call(1'b1, 5'h05, 5'h1e, 1'b0, 1'b1, 4'h9);
    for (int k = 0; k < 4; k++) call(1'b1, 5'h05, 5'h10 + k[4:0], 1'b0, 1'b1, 4'hf);
    call(1'b1, 5'h05, INFO_SET_ID2, 1'b0, 1'b1, REPLY_ACK);
    call(1'b1, 5'h00, 5'h1d, 1'b0, 1'b0, 4'h0);
    regw(REG_CFG, 16'h00c0);
    call(1'b1, 5'h05, INFO_SET_ID2, 1'b0, 1'b0, 4'h0);
    regw(REG_CFG, 16'h0043);
    call(1'b0, 5'h05, 5'h0f, 1'b0, 1'b0, 4'h0);
    call(1'b0, 5'h05, 5'h07, 1'b0, 1'b1, 4'h3);
    chk("dout", {12'h000, DATA_OUT}, 16'h000c);
    regw(REG_CFG, 16'h0000);
    call(1'b1, 5'h05, 5'h1c, 1'b0, 1'b1, REPLY_ACK);
    chk("dout", {12'h000, DATA_OUT}, 16'h0000);
  endtask
  task automatic t_safety();
    regw(REG_CFG, 16'h0308);
    #1 chk("lvl3", {14'h0000, INPUT_3LEVEL, FILTER_ACTIVE}, 16'h0002);
    for (int i = 0; i < 8; i++) regw(REG_TABLE, {8'h00, 4'hc ^ i[3:0], 1'b0, i[2:0]});
    for (int i = 0; i < 8; i++) call(1'b0, 5'h05, 5'h00, 1'b0, 1'b1, 4'hc ^ i[3:0]);
    regw(REG_CFG, 16'h0000);
  endtask
  task automatic t_led();
    call(1'b0, 5'h05, 5'h00, 1'b0, 1'b1, 4'h3);
    repeat (38 * TCK) @(posedge MCLK);
    #1 chk("led", {15'h0000, FIRST_LED_OUTPUT}, 16'h0000);
    repeat (7 * TCK) @(posedge MCLK);
    #1 chk("led", {15'h0000, FIRST_LED_OUTPUT}, 16'h0001);
    call(1'b0, 5'h05, 5'h00, 1'b0, 1'b1, 4'h3);
    repeat (2) @(posedge MCLK);
    #1 chk("led", {15'h0000, FIRST_LED_OUTPUT}, 16'h0000);
  endtask
  // ---
  // run
  // ---
  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end
  initial begin
    #2000000;
    bad_count++;
    conclude();
  end
  initial begin
    {RSTN, EE_WRITE_PENDING, SECURITY_FLAG, REG_WR, REG_RD} = 5'h00;
    {DATA_IN, PARAM_IN, REG_ADDR_IN} = 12'h000;
    REG_WDATA = 16'h0000;
    repeat (2) @(posedge MCLK);
    RSTN <= 1'b1;
    t_basic();
    t_calls();
    t_safety();
    t_led();
    conclude();
  end
endmodule
`default_nettype wire
